// File: core/lane_steer.sv
// Byte-lane steering and dynamic bus sizing sequencer
`timescale 1ns/1ps
module lane_steer (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire lane_steer_pkg::req_t req_i,
    input wire logic req_valid_i,
    input wire logic port_ack_hi_i,
    input wire logic port_ack_lo_i,
    input wire logic [31:0] data_in_i,
    output logic [31:0] data_out_o,
    output logic data_oe_o,
    output logic [31:0] addr_o,
    output logic remaining_size_hi_o,
    output logic remaining_size_lo_o,
    output logic cycle_active_o,
    output logic write_o,
    output logic [31:0] rd_data_o,
    output logic done_o,
    output logic busy_o
);

    lane_steer_pkg::state_reg_t q, d;

    // Size encoding of a remaining byte count
    function automatic logic [1:0] size_code(input logic [2:0] n);
        // Zero never gets here: an idle block refuses a zero count
        unique case (n)
            lane_steer_pkg::BYTES_ONE: size_code = lane_steer_pkg::SIZE_ONE;
            lane_steer_pkg::BYTES_TWO: size_code = lane_steer_pkg::SIZE_TWO;
            3'h3: size_code = lane_steer_pkg::SIZE_THREE;
            default: size_code = lane_steer_pkg::SIZE_FOUR;
        endcase
    endfunction

    // Write multiplexer; op[0] is the most significant operand byte
    function automatic logic [31:0] steer(input logic [31:0] opd, input logic [1:0] sz, input logic [1:0] off);
        logic [7:0] b0, b1, b2, b3;
        b0 = opd[31:24];
        b1 = opd[23:16];
        b2 = opd[15:8];
        b3 = opd[7:0];
        steer = {b0, b1, b2, b3};
        // Pattern per size and offset; some lanes carry a byte no port uses
        unique case (sz)
            lane_steer_pkg::SIZE_ONE: steer = {b3, b3, b3, b3};
            lane_steer_pkg::SIZE_TWO:
                steer = off[0] ? {b2, b2, b3, b2} : {b2, b3, b2, b3};
            lane_steer_pkg::SIZE_THREE:
                unique case (off)
                    2'h0: steer = {b1, b2, b3, b0}; // Low lane unused
                    2'h1: steer = {b1, b1, b2, b3};
                    2'h2: steer = {b1, b2, b1, b2};
                    default: steer = {b1, b1, b2, b1}; // Lane 1 unused
                endcase
            default:
                unique case (off)
                    2'h0: steer = {b0, b1, b2, b3};
                    2'h1: steer = {b0, b0, b1, b2};
                    2'h2: steer = {b0, b1, b0, b1};
                    default: steer = {b0, b0, b1, b0}; // Lane 1 unused
                endcase
        endcase
    endfunction

    // Bytes actually taken: port width limited by offset and remaining
    function automatic logic [2:0] taken(input logic hi, input logic lo, input logic [1:0] off, input logic [2:0] rem);
        logic [2:0] cap;
        // Default is the 8-bit port: one byte per cycle
        cap = 3'h1;
        if (hi && lo)
            cap = 3'(4 - off);
        else if (hi)
            cap = off[0] ? 3'h1 : 3'h2;
        taken = (cap < rem) ? cap : rem;
    endfunction

    // Lane, counted from the top, that holds read byte i for the answering port
    function automatic logic [1:0] rd_lane(input logic hi, input logic lo,
        input logic [1:0] off, input logic [2:0] i);
        if (hi && lo)
            rd_lane = 2'(off + i); // 32-bit port follows the offset
        else if (hi)
            rd_lane = 2'({1'b0, off[0]} + i); // 16-bit port on the top two lanes
        else
            rd_lane = 2'h0; // 8-bit port only has the top lane
    endfunction

    // Next-state logic
    // Acks are levels, not edges: the port must drop its ack after one cycle,
    // before the update, or the same ack is counted for the next cycle
    always_comb
    begin
        logic [2:0] n;
        logic [1:0] off;
        logic [31:0] lanes;
        logic [2:0] left;
        logic [1:0] lane;
        logic [1:0] dst;
        n = 3'h0;
        off = q.addr[1:0];
        lanes = q.din_s2;
        left = 3'h0;
        lane = 2'h0;
        dst = 2'h0;
        // Hold everything by default; only the fields below move
        d = q;
        d.done = 1'b0;
        // Two-flop synchronisers on pin inputs; read lanes ride with the acks so data lines up
        d.ack_hi_s1 = port_ack_hi_i;
        d.ack_lo_s1 = port_ack_lo_i;
        d.ack_hi_s2 = q.ack_hi_s1;
        d.ack_lo_s2 = q.ack_lo_s1;
        d.din_s1 = data_in_i;
        d.din_s2 = q.din_s1;
        unique case (q.state)
            lane_steer_pkg::ST_IDLE:
            begin
                // A zero count is refused; requests are only looked at while idle
                if (req_valid_i && req_i.bytes != lane_steer_pkg::BYTES_ZERO)
                begin
                    // Operand and count latched whole; the core may move on once busy is up
                    d.state = lane_steer_pkg::ST_CYCLE;
                    d.addr = req_i.addr;
                    d.operand = req_i.data;
                    d.remaining = req_i.bytes;
                    d.write = req_i.write;
                    d.size = size_code(req_i.bytes);
                    d.bus_data = steer(req_i.data, size_code(req_i.bytes), req_i.addr[1:0]);
                    d.bus_oe = req_i.write;
                    d.cycle_active = 1'b1;
                    d.busy = 1'b1;
                end
            end
            lane_steer_pkg::ST_CYCLE:
            begin
                // Both acks negated means wait states
                if (q.ack_hi_s2 || q.ack_lo_s2)
                begin
                    n = taken(q.ack_hi_s2, q.ack_lo_s2, off, q.remaining);
                    if (!q.write)
                    begin
                        // Narrow ports return data on the top lanes
                        for (int i = 0; i < 4; i++)
                        begin
                            if (i < n)
                            begin
                                lane = rd_lane(q.ack_hi_s2, q.ack_lo_s2, off, 3'(i));
                                // Bytes already fetched sit above this cycle's bytes
                                dst = 2'(4 - q.remaining + i);
                                d.rd_data[8 * (3 - dst) +: 8] = lanes[8 * (3 - lane) +: 8];
                            end
                        end
                    end
                    // Address and count move by what the port took
                    left = q.remaining - n;
                    d.addr = q.addr + 32'(n);
                    d.remaining = left;
                    if (left == lane_steer_pkg::BYTES_ZERO)
                    begin
                        // Last bytes gone: release the bus, pulse done for one cycle
                        d.state = lane_steer_pkg::ST_IDLE;
                        d.cycle_active = 1'b0;
                        d.bus_oe = 1'b0;
                        d.busy = 1'b0;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        // Next cycle, e.g. 1010 after a 16-bit ack
                        d.size = size_code(left);
                        // Unsent bytes stay right-justified, so low bytes go high
                        d.bus_data = steer(q.operand, size_code(left), 2'(off + n[1:0]));
                    end
                end
            end
            default: d.state = lane_steer_pkg::ST_IDLE;
        endcase
    end

    // State register; clock enable freezes everything
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Reset wins over the clock enable
            q <= '0;
            q.state <= lane_steer_pkg::ST_IDLE;
            q.addr <= lane_steer_pkg::ADDR_RESET;
            q.bus_data <= lane_steer_pkg::DATA_RESET;
        end
        else if (clk_en_i)
            q <= d;
    end

    // Outputs straight from the state flops, so pins never see a glitch
    assign data_out_o = q.bus_data;
    assign data_oe_o = q.bus_oe;
    assign addr_o = q.addr;
    assign remaining_size_hi_o = q.size[1];
    assign remaining_size_lo_o = q.size[0];
    assign cycle_active_o = q.cycle_active;
    assign write_o = q.write;
    assign rd_data_o = q.rd_data;
    assign done_o = q.done;
    assign busy_o = q.busy;

endmodule

// File: core/lane_steer_pkg.sv
// Package: encodings, carriers and constants for the byte-lane steering block
package lane_steer_pkg;

    // Remaining-size encodings driven on the size outputs
    localparam logic [1:0] SIZE_ONE = 2'h1;
    localparam logic [1:0] SIZE_TWO = 2'h2;
    localparam logic [1:0] SIZE_THREE = 2'h3;
    localparam logic [1:0] SIZE_FOUR = 2'h0;

    // Byte counts used by the sequencer
    localparam logic [2:0] BYTES_ZERO = 3'h0;
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_TWO = 3'h2;
    localparam logic [2:0] BYTES_FOUR = 3'h4;

    // Reset values
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CYCLE = 2'b01
    } state_t;

    // Transfer request from the core side
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [2:0] bytes;
        logic write;
    } req_t;

    // Whole register state of the block
    typedef struct packed {
        state_t state;
        logic [31:0] addr;
        logic [31:0] operand;
        logic [2:0] remaining;
        logic write;
        logic [31:0] bus_data;
        logic bus_oe;
        logic cycle_active;
        logic [1:0] size;
        logic [31:0] rd_data;
        logic done;
        logic busy;
        logic ack_hi_s1;
        logic ack_lo_s1;
        logic ack_hi_s2;
        logic ack_lo_s2;
        logic [31:0] din_s1;
        logic [31:0] din_s2;
    } state_reg_t;

endpackage

// File: tb/lane_steer_properties.sv
// Checker for lane patterns and cycle sequencing of the steering block
`timescale 1ns/1ps
module lane_steer_properties (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] data_out_o,
    input wire logic data_oe_o,
    input wire logic [31:0] addr_o,
    input wire logic remaining_size_hi_o,
    input wire logic remaining_size_lo_o,
    input wire logic cycle_active_o,
    input wire logic write_o,
    input wire logic done_o,
    input wire logic busy_o
);
    logic [1:0] sz;
    logic [1:0] off;
    logic [7:0] b3, b2, b1, b0;
    logic wr;
    // Lane bytes from most to least significant
    assign {b3, b2, b1, b0} = data_out_o;
    assign sz = {remaining_size_hi_o, remaining_size_lo_o};
    assign off = addr_o[1:0];
    assign wr = cycle_active_o && write_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    one_lane_a: assert property (wr && sz == 2'h1 |-> b3 == b0 && b2 == b0 && b1 == b0)
        else $error("single byte not on all lanes");
    word_even_a: assert property (wr && sz == 2'h2 && !off[0] |-> b3 == b1 && b2 == b0)
        else $error("even word lanes wrong");
    word_odd_a: assert property (wr && sz == 2'h2 && off[0] |-> b3 == b2 && b3 == b0)
        else $error("odd word lanes wrong");
    three_mix_a: assert property (wr && sz == 2'h3 |-> (off != 2'h1 || b3 == b2) && (off != 2'h2 ||
        b3 == b1 && b2 == b0) && (off != 2'h3 || b3 == b2 && b3 == b0)) else $error("three byte lanes wrong");
    four_mix_a: assert property (wr && sz == 2'h0 |-> (off != 2'h1 || b3 == b2) && (off != 2'h2 ||
        b3 == b1 && b2 == b0) && (off != 2'h3 || b3 == b2 && b3 == b0)) else $error("four byte lanes wrong");
    // Acks pass a two-flop sync, so no cycle can move before its third edge
    hold_wait_a: assert property ($rose(cycle_active_o) |=> $stable({addr_o, sz}) [*2])
        else $error("cycle changed before ack");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_idle_a: assert property (done_o |-> !busy_o && !cycle_active_o)
        else $error("busy after done");
    oe_dir_a: assert property (data_oe_o == wr)
        else $error("lane drive not tied to write cycles");
    cover property (wr && sz == 2'h3);
    cover property (wr && sz == 2'h0 && off == 2'h3);
    cover property (done_o && !write_o);
endmodule

// File: tb/slave_port.sv
// Slave port model of selectable width with wait states
`timescale 1ns/1ps
module slave_port (
    input wire logic mclk_i,
    input wire logic cyc_i,
    input wire logic wr_i,
    input wire logic [31:0] addr_i,
    input wire logic [1:0] sz_i,
    input wire logic [31:0] dout_i,
    input wire logic [2:0] pb_i,
    input wire logic [3:0] wt_i,
    output logic ack_hi_o,
    output logic ack_lo_o,
    output logic [31:0] din_o
);
    logic [7:0] mem [0:15];
    int cnt = 0;
    int n;
    int off;
    initial din_o = 32'h0;
    // Bytes this port moves, clipped by the remaining size
    always_comb
    begin
        off = int'(addr_i[1:0]) % int'(pb_i);
        n = int'(pb_i) - off;
        if (sz_i != 2'h0 && int'(sz_i) < n)
            n = int'(sz_i);
    end
    // One-cycle ack, then a gap so the synced level is not counted twice
    always @(posedge mclk_i)
    begin
        ack_hi_o <= 1'b0;
        ack_lo_o <= 1'b0;
        din_o <= ~din_o;
        if (!cyc_i)
            cnt <= 0;
        else if (cnt == int'(wt_i))
        begin
            ack_hi_o <= pb_i != 3'h1;
            ack_lo_o <= pb_i != 3'h2;
            cnt <= -4;
            for (int k = 0; k < n; k++)
                if (wr_i)
                    mem[addr_i[3:0] + k] <= dout_i[31 - 8 * (off + k) -: 8];
        end
        else
            cnt <= cnt + 1;
        if (cyc_i && !wr_i)
            for (int k = 0; k < n; k++)
                din_o[31 - 8 * (off + k) -: 8] <= mem[addr_i[3:0] + k];
    end
endmodule

// File: tb/tb_lane_steer.sv
// Testbench for the byte-lane steering block
`timescale 1ns/1ps
bind lane_steer lane_steer_properties u_prop (.mclk_i, .sys_rst_i, .data_out_o, .addr_o, .remaining_size_hi_o,
    .data_oe_o, .remaining_size_lo_o, .cycle_active_o, .write_o, .done_o, .busy_o);
module tb_lane_steer;
    logic mclk_i = 0;
    logic sys_rst_i = 1;
    lane_steer_pkg::req_t req = '0;
    logic req_v = 0;
    logic ah, al, oe, cyc, wr, szh, szl, done, busy;
    logic [31:0] din, dout, addr, rd;
    logic [2:0] pb = 3'h4;
    logic [3:0] wt = 4'h0;
    logic en = 1;
    logic [31:0] lg_d [0:7];
    logic [3:0] lg_c [0:7];
    int n_log = 0;
    int n_mismatch = 0;
    int tests_run = 0;
    lane_steer u_dut (.mclk_i, .sys_rst_i, .clk_en_i(en), .req_i(req), .req_valid_i(req_v), .port_ack_hi_i(ah),
        .port_ack_lo_i(al), .data_in_i(din), .data_out_o(dout), .data_oe_o(oe), .addr_o(addr),
        .remaining_size_hi_o(szh), .remaining_size_lo_o(szl), .cycle_active_o(cyc), .write_o(wr),
        .rd_data_o(rd), .done_o(done), .busy_o(busy));
    slave_port u_slave (.mclk_i, .cyc_i(cyc), .wr_i(wr), .addr_i(addr), .sz_i({szh, szl}), .dout_i(dout),
        .pb_i(pb), .wt_i(wt), .ack_hi_o(ah), .ack_lo_o(al), .din_o(din));
    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end
    // Log lanes and size/offset of each acknowledged cycle
    always @(posedge mclk_i)
    begin
        if ((ah | al) && n_log < 8)
        begin
            lg_d[n_log] = dout;
            lg_c[n_log] = {szh, szl, addr[1:0]};
            n_log++;
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task xfer(input logic [31:0] a, input logic [31:0] d, input logic [2:0] b, input logic w, input int p, int t);
        @(posedge mclk_i);
        #1;
        pb = 3'(p);
        wt = 4'(t);
        req = '{addr: a, data: d, bytes: b, write: w};
        req_v = 1;
        n_log = 0;
        @(posedge mclk_i);
        #1;
        req_v = 0;
        for (int i = 0; i < 300 && done !== 1'b1; i++)
            #50;
        chk("done", done, 1'b1);
    endtask
    task s_lw16;
        xfer(32'h0, 32'h1122_3344, 3'h4, 1'b1, 2, 0);
        chk("cycles", 32'(n_log), 32'h2);
        chk("c0 ctl", lg_c[0], 4'h0);
        chk("c0 lanes", lg_d[0], 32'h1122_3344);
        chk("c1 ctl", lg_c[1], 4'ha);
        chk("c1 upper", lg_d[1][31:16], 16'h3344);
    endtask
    task s_w8;
        xfer(32'h4, 32'h5566, 3'h2, 1'b1, 1, 1);
        chk("ctl", {lg_c[0], lg_c[1]}, 8'h85);
        chk("cycles", 32'(n_log), 32'h2);
        chk("lanes0", lg_d[0], 32'h5566_5566);
        chk("lanes1", lg_d[1], 32'h6666_6666);
        xfer(32'h5, 32'h0, 3'h1, 1'b0, 1, 2);
        chk("rd byte", rd[7:0], 8'h66);
    endtask
    task s_mis32;
        xfer(32'h3, 32'haabb_ccdd, 3'h4, 1'b1, 4, 2);
        chk("ctl", {lg_c[0], lg_c[1]}, 8'h3c);
        chk("lanes0", lg_d[0], 32'haaaa_bbaa);
        chk("lanes1", lg_d[1], 32'hbbcc_ddaa);
    endtask
    // Clock enable low: a waiting request must not be taken
    task s_freeze;
        @(posedge mclk_i);
        #1;
        en = 0;
        req = '{addr: 32'h1, data: 32'h0000_0077, bytes: 3'h1, write: 1'b1};
        req_v = 1;
        repeat (3) @(posedge mclk_i);
        #1;
        req_v = 0;
        en = 1;
        chk("frozen", {busy, cyc}, 2'h0);
        xfer(32'h1, 32'h0000_0077, 3'h1, 1'b1, 4, 0);
        chk("c0 ctl", lg_c[0], 4'h5);
        chk("lanes", lg_d[0], 32'h7777_7777);
        chk("mem1", u_slave.mem[1], 8'h77);
    endtask
    // Every port width at every offset, written then read back
    task s_sweep;
        logic [31:0] v;
        logic [31:0] m;
        for (int p = 1; p <= 4; p = p * 2)
            for (int o = 0; o < 4; o++)
            begin
                v = 32'h1b2c_3d4e ^ {4{8'(p * 16 + o)}};
                xfer(32'(8 + o), v, 3'h4, 1'b1, p, 0);
                m = {u_slave.mem[8 + o], u_slave.mem[9 + o], u_slave.mem[10 + o], u_slave.mem[11 + o]};
                chk("mem", m, v);
                xfer(32'(8 + o), 32'h0, 3'h4, 1'b0, p, 3);
                chk("read", rd, v);
            end
    endtask
    task wrap_up;
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles; this cuts a hang short
    initial
    begin
        #600000;
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        repeat (10) @(posedge mclk_i);
        #1;
        sys_rst_i = 0;
        s_lw16();
        s_w8();
        s_mis32();
        s_freeze();
        s_sweep();
        wrap_up();
    end
endmodule
